// >>> logic/fss_session.sv
/*
 fss_session: fax session signalling sequencer for both calling and
 answering roles. Sends training, training check, image bits, the
 end-of-sheet marker and post-message frames; answers the far end's
 check result, page result and operator call.
 Assumes a modem below that turns frame codes into frames, sends the
 training pattern while asked, and reports received frames and checks.
*/
`timescale 1ns/10ps
module fss_session #(
   parameter int TCF_CYCLES = fss_pkg::TCF_MS * fss_pkg::CLK_KHZ
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic role_caller,
   input wire logic start_send,
   input wire logic [2:0] start_rate,
   input wire logic more_pages,
   input wire logic operator_call,
   input wire logic img_bit,
   input wire logic img_last,
   input wire logic rx_frame_valid,
   input wire logic [7:0] rx_frame_code,
   input wire logic rx_tcf_done,
   input wire logic rx_tcf_good,
   input wire logic rx_page_good,
   input wire logic tx_frame_ready,
   output logic tx_frame_valid,
   output logic [7:0] tx_frame_code,
   output logic train_active,
   output logic [2:0] tx_rate,
   output logic tx_bit,
   output logic tx_bit_valid,
   output logic img_ready,
   output logic coding_1d_only,
   output logic op_call_seen,
   output logic session_done
);
   // =====================================================
   // state
   typedef struct packed {
      fss_pkg::fss_state_t st; // session phase
      logic [2:0] rate; // current rate step
      logic [27:0] cnt; // cycle count within a timed phase
      logic [3:0] rtc_n; // marker bits sent
      logic [1:0] ph; // position within 001
      logic pend; // frame waiting for the modem
      logic [7:0] code; // frame code waiting
      logic [6:0] last; // last post-message frame sent
      logic bit_ff; // serial bit out
      logic bitv; // serial bit valid
      logic opc; // operator call answered, one cycle
      logic done; // session closed, one cycle
   } fss_reg_t;

   fss_reg_t cur_ff; // registered state
   fss_reg_t nxt_cur; // next state

   // check length needs the full counter width
   localparam logic [27:0] TRAIN_LIM = 28'(fss_pkg::TRAIN_CYC - 1);
   localparam logic [27:0] TCF_LIM = 28'(TCF_CYCLES - 1);

   // =====================================================
   // decode
   // low seven bits only: the leading bit depends on who called
   function automatic logic is_code(input logic [7:0] rx, input logic [6:0] c);
      is_code = (rx[6:0] == c);
   endfunction

   // a matched frame from the far end this cycle
   logic got_cfr;
   logic got_ftt;
   logic got_mcf;
   logic got_pip;
   logic got_pri;
   assign got_cfr = rx_frame_valid && is_code(rx_frame_code, fss_pkg::C_CFR);
   assign got_ftt = rx_frame_valid && is_code(rx_frame_code, fss_pkg::C_FTT);
   assign got_mcf = rx_frame_valid && is_code(rx_frame_code, fss_pkg::C_MCF);
   assign got_pip = rx_frame_valid && is_code(rx_frame_code, fss_pkg::C_PIP);
   assign got_pri = rx_frame_valid && is_code(rx_frame_code, fss_pkg::C_PRI);

   // =====================================================
   // next state
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.bitv = 1'b0;
      nxt_cur.bit_ff = 1'b0;
      nxt_cur.opc = 1'b0;
      nxt_cur.done = 1'b0;
      // modem took the frame
      if (cur_ff.pend && tx_frame_ready) begin
         nxt_cur.pend = 1'b0;
      end
      case (cur_ff.st)
         fss_pkg::S_IDLE: begin
            // answering side: replies only while not sending
            if (!cur_ff.pend) begin
               if (rx_tcf_done) begin
                  nxt_cur.pend = 1'b1;
                  // good check confirms, bad one fails
                  nxt_cur.code = {role_caller,
                     rx_tcf_good ? fss_pkg::C_CFR : fss_pkg::C_FTT};
               end else if (rx_page_good) begin
                  nxt_cur.pend = 1'b1;
                  nxt_cur.code = {role_caller, fss_pkg::C_MCF};
               end else if (got_pri) begin
                  nxt_cur.pend = 1'b1;
                  nxt_cur.code = {role_caller, fss_pkg::C_PIP};
                  nxt_cur.opc = 1'b1;
               end else if (start_send) begin
                  // clamp rate to the fastest step
                  nxt_cur.rate = (start_rate > fss_pkg::RATE_MAX) ?
                     fss_pkg::RATE_MAX : start_rate;
                  nxt_cur.cnt = '0;
                  nxt_cur.st = fss_pkg::S_TRAIN1;
               end
            end
         end
         fss_pkg::S_TRAIN1: begin
            // modem sends the fixed pattern at tx_rate
            nxt_cur.cnt = cur_ff.cnt + 28'h1;
            if (cur_ff.cnt == TRAIN_LIM) begin
               nxt_cur.cnt = '0;
               nxt_cur.st = fss_pkg::S_TCF;
            end
         end
         fss_pkg::S_TCF: begin
            // continuous zeros at the training rate
            nxt_cur.bitv = 1'b1;
            nxt_cur.cnt = cur_ff.cnt + 28'h1;
            if (cur_ff.cnt == TCF_LIM) begin
               nxt_cur.bitv = 1'b0;
               nxt_cur.cnt = '0;
               nxt_cur.st = fss_pkg::S_WCONF;
            end
         end
         fss_pkg::S_WCONF: begin
            if (got_cfr) begin
               nxt_cur.st = fss_pkg::S_TRAIN2;
            end else if (got_ftt) begin
               // already slowest: retrain at the same rate
               if (cur_ff.rate != fss_pkg::RATE_MIN) begin
                  nxt_cur.rate = cur_ff.rate - 3'h1;
               end
               nxt_cur.st = fss_pkg::S_TRAIN1;
            end
         end
         fss_pkg::S_TRAIN2: begin
            // same form as the first training
            nxt_cur.cnt = cur_ff.cnt + 28'h1;
            if (cur_ff.cnt == TRAIN_LIM) begin
               nxt_cur.cnt = '0;
               nxt_cur.st = fss_pkg::S_IMAGE;
            end
         end
         fss_pkg::S_IMAGE: begin
            // coded bits pass straight through
            nxt_cur.bitv = 1'b1;
            nxt_cur.bit_ff = img_bit;
            if (img_last) begin
               nxt_cur.rtc_n = '0;
               nxt_cur.ph = '0;
               nxt_cur.st = fss_pkg::S_RTC;
            end
         end
         fss_pkg::S_RTC: begin
            // one marker bit per cycle: 0,0,1 repeated
            nxt_cur.bitv = 1'b1;
            nxt_cur.bit_ff = (cur_ff.ph == fss_pkg::RTC_PER);
            nxt_cur.ph = (cur_ff.ph == fss_pkg::RTC_PER) ? 2'h0 : cur_ff.ph + 2'h1;
            nxt_cur.rtc_n = cur_ff.rtc_n + 4'h1;
            if (cur_ff.rtc_n == fss_pkg::RTC_BITS - 4'h1) begin
               nxt_cur.st = fss_pkg::S_POST;
            end
         end
         fss_pkg::S_POST: begin
            // operator call wins over more pages, which wins over the end
            if (!cur_ff.pend) begin
               nxt_cur.pend = 1'b1;
               if (operator_call) begin
                  nxt_cur.last = fss_pkg::C_PRI;
               end else if (more_pages) begin
                  nxt_cur.last = fss_pkg::C_MPS;
               end else begin
                  nxt_cur.last = fss_pkg::C_EOP;
               end
               nxt_cur.code = {role_caller, nxt_cur.last};
               nxt_cur.st = fss_pkg::S_WRESP;
            end
         end
         fss_pkg::S_WRESP: begin
            if (got_mcf && cur_ff.last == fss_pkg::C_MPS) begin
               nxt_cur.st = fss_pkg::S_IMAGE;
            end else if (got_mcf || got_pip) begin
               nxt_cur.opc = got_pip;
               nxt_cur.st = fss_pkg::S_DISC;
            end
         end
         fss_pkg::S_DISC: begin
            // release starts with the disconnect frame
            if (!cur_ff.pend) begin
               nxt_cur.pend = 1'b1;
               nxt_cur.code = {role_caller, fss_pkg::C_DCN};
               nxt_cur.done = 1'b1;
               nxt_cur.st = fss_pkg::S_IDLE;
            end
         end
         default: begin
            nxt_cur.st = fss_pkg::S_IDLE;
         end
      endcase
   end

   // =====================================================
   // registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // =====================================================
   // outputs
   assign tx_frame_valid = cur_ff.pend;
   assign tx_frame_code = cur_ff.code;
   assign train_active = (cur_ff.st == fss_pkg::S_TRAIN1) ||
      (cur_ff.st == fss_pkg::S_TRAIN2);
   assign tx_rate = cur_ff.rate;
   assign tx_bit = cur_ff.bit_ff;
   assign tx_bit_valid = cur_ff.bitv;
   assign img_ready = (cur_ff.st == fss_pkg::S_IMAGE);
   // no two-dimensional coder exists behind this block
   assign coding_1d_only = 1'b1;
   assign op_call_seen = cur_ff.opc;
   assign session_done = cur_ff.done;

   // =====================================================
   // checks
   tcf_zeros_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(cur_ff.st == fss_pkg::S_TCF) |=> tx_bit_valid && !tx_bit)
      else $error("check bits not zero");
   cfr_reply_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cur_ff.st == fss_pkg::S_IDLE && !cur_ff.pend && rx_tcf_done && rx_tcf_good
      |=> tx_frame_valid && tx_frame_code[6:0] == fss_pkg::C_CFR)
      else $error("no confirm after good check");
   ftt_reply_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cur_ff.st == fss_pkg::S_IDLE && !cur_ff.pend && rx_tcf_done && !rx_tcf_good
      |=> tx_frame_valid && tx_frame_code[6:0] == fss_pkg::C_FTT)
      else $error("no failure frame after bad check");
   rate_step_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cur_ff.st == fss_pkg::S_WCONF && got_ftt && !got_cfr && tx_rate != 3'h0
      |=> tx_rate == $past(tx_rate) - 3'h1 && train_active)
      else $error("rate not stepped down");
   rtc_mark_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(cur_ff.st == fss_pkg::S_RTC) |=> !tx_bit ##1 !tx_bit ##1 tx_bit
      ##1 !tx_bit ##1 !tx_bit ##1 tx_bit)
      else $error("marker pattern wrong");
   rtc_len_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(cur_ff.st == fss_pkg::S_RTC) |-> (cur_ff.st == fss_pkg::S_RTC)[*8]
      ##5 cur_ff.st == fss_pkg::S_POST)
      else $error("marker length wrong");
   post_pick_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cur_ff.st == fss_pkg::S_POST && !cur_ff.pend && !operator_call && more_pages
      |=> tx_frame_code[6:0] == fss_pkg::C_MPS)
      else $error("multi-page frame not sent");
   pri_pick_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cur_ff.st == fss_pkg::S_POST && !cur_ff.pend && operator_call
      |=> tx_frame_code[6:0] == fss_pkg::C_PRI)
      else $error("interrupt frame not sent");
   next_sheet_a: assert property (@(posedge core_clk) disable iff (!nrst)
      cur_ff.st == fss_pkg::S_WRESP && got_mcf && cur_ff.last == fss_pkg::C_MPS
      |=> img_ready)
      else $error("next sheet not started");
   dcn_end_a: assert property (@(posedge core_clk) disable iff (!nrst)
      session_done |-> tx_frame_valid && tx_frame_code[6:0] == fss_pkg::C_DCN)
      else $error("release without disconnect");
   role_bit_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(tx_frame_valid) |-> tx_frame_code[7] == $past(role_caller))
      else $error("role bit wrong");
   train2_first_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(img_ready) |-> $past(cur_ff.st) == fss_pkg::S_TRAIN2
      || $past(cur_ff.st) == fss_pkg::S_WRESP)
      else $error("image without second training");

   fallback_c: cover property (@(posedge core_clk) disable iff (!nrst)
      cur_ff.st == fss_pkg::S_WCONF && got_ftt);
   multipage_c: cover property (@(posedge core_clk) disable iff (!nrst)
      cur_ff.st == fss_pkg::S_WRESP && got_mcf && cur_ff.last == fss_pkg::C_MPS);
   opcall_c: cover property (@(posedge core_clk) disable iff (!nrst) op_call_seen);
   done_c: cover property (@(posedge core_clk) disable iff (!nrst) session_done);
endmodule

// >>> logic/fss_pkg.sv
/*
 fss_pkg: constants shared by the fax session signalling block.
 Holds control codes, rate steps, timing figures and the state encoding.
 Assumes a 125 MHz core clock.
*/
package fss_pkg;
   // core clock in kHz, used to turn milliseconds into cycles
   localparam int CLK_KHZ = 125000;
   // training-check length in milliseconds
   localparam int TCF_MS = 1500;
   // default training length in cycles; the modem sets the real pattern
   localparam int TRAIN_CYC = 1000;
   // return-to-control length in bits and the last phase of the three-bit 001 repeat
   localparam logic [3:0] RTC_BITS = 4'hc;
   localparam logic [1:0] RTC_PER = 2'h2;
   // rate steps: 0 = 2400 bit/s up to 5 = 14400 bit/s
   localparam logic [2:0] RATE_MAX = 3'h5;
   localparam logic [2:0] RATE_MIN = 3'h0;
   // control codes, low seven bits; bit 7 is the role bit
   localparam logic [6:0] C_CFR = 7'h21;
   localparam logic [6:0] C_FTT = 7'h22;
   localparam logic [6:0] C_EOP = 7'h74;
   localparam logic [6:0] C_DCN = 7'h5f;
   localparam logic [6:0] C_MCF = 7'h31;
   localparam logic [6:0] C_MPS = 7'h72;
   localparam logic [6:0] C_PRI = 7'h7c;
   localparam logic [6:0] C_PIP = 7'h35;
   // session states, gray along the sending path
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_TRAIN1 = 4'h1,
      S_TCF = 4'h3,
      S_WCONF = 4'h2,
      S_TRAIN2 = 4'h6,
      S_IMAGE = 4'h7,
      S_RTC = 4'h5,
      S_POST = 4'h4,
      S_WRESP = 4'hc,
      S_DISC = 4'hd
   } fss_state_t;
endpackage

// >>> tb/fss_remote_model.sv
/*
 fss_remote_model: the far fax terminal as seen through its modem.
 Takes frames from the sequencer and, when the bench calls its tasks,
 reports received frames, check results and page results.
 Assumes one core clock shared with the sequencer.
*/
`timescale 1ns/10ps
module fss_remote_model (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic tx_frame_valid,
   input wire logic [7:0] tx_frame_code,
   output logic tx_frame_ready,
   output logic rx_frame_valid,
   output logic [7:0] rx_frame_code,
   output logic rx_tcf_done,
   output logic rx_tcf_good,
   output logic rx_page_good
);
   // ==========================================================
   // frame sink
   int stall = 0; // pending cycles before ready; above 0 is a slow modem
   int wait_cnt = 0; // cycles the pending frame has waited
   int n_frames = 0; // frames taken so far
   logic [7:0] last_code = 8'h00; // last frame taken
   // idle report lines; the code line never rests on a real code
   initial begin
      tx_frame_ready = 1'b0;
      rx_frame_valid = 1'b0;
      rx_frame_code = 8'hff;
      rx_tcf_done = 1'b0;
      rx_tcf_good = 1'b1;
      rx_page_good = 1'b0;
   end
   // ready rises only after the stall, drops right after the take
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tx_frame_ready <= 1'b0;
         wait_cnt <= 0;
      end else if (tx_frame_valid && tx_frame_ready) begin
         n_frames <= n_frames + 1;
         last_code <= tx_frame_code;
         tx_frame_ready <= 1'b0;
         wait_cnt <= 0;
      end else if (tx_frame_valid) begin
         if (wait_cnt >= stall) begin
            tx_frame_ready <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt + 1;
         end
      end
   end
   // ==========================================================
   // far-end reports, one cycle each
   // a frame from the far end; afterwards the code line shows its inverse
   task automatic send_frame(input logic [7:0] code);
      @(posedge core_clk);
      rx_frame_valid <= 1'b1;
      rx_frame_code <= code;
      @(posedge core_clk);
      rx_frame_valid <= 1'b0;
      rx_frame_code <= ~code;
   endtask
   // result of the training check as judged by the local modem
   task automatic tcf_result(input logic good);
      @(posedge core_clk);
      rx_tcf_done <= 1'b1;
      rx_tcf_good <= good;
      @(posedge core_clk);
      rx_tcf_done <= 1'b0;
      rx_tcf_good <= ~good;
   endtask
   // page arrived intact
   task automatic page_ok;
      @(posedge core_clk);
      rx_page_good <= 1'b1;
      @(posedge core_clk);
      rx_page_good <= 1'b0;
   endtask
endmodule

// >>> tb/fss_session_tb.sv
/*
 testbench: runs the session sequencer through answering, rate fallback,
 multi-page and operator-call sessions, judging frames and serial bits.
 Assumes fss_pkg, fss_session and fss_remote_model are compiled first.
*/
`timescale 1ns/10ps
module testbench;
   // ==========================================================
   // signals and monitors
   localparam int TCF_N = 20; // short check so the run stays brief
   localparam int LIMIT = 20000; // about three times the planned run
   localparam logic [7:0] PAT = 8'ha5; // image bits, bit 7 goes first
   logic core_clk, nrst, role_caller, start_send, more_pages, operator_call, img_bit, img_last;
   logic [2:0] start_rate, tx_rate;
   logic [7:0] rx_frame_code, tx_frame_code;
   logic rx_frame_valid, rx_tcf_done, rx_tcf_good, rx_page_good, tx_frame_ready;
   logic tx_frame_valid, train_active, tx_bit, tx_bit_valid, img_ready;
   logic coding_1d_only, op_call_seen, session_done;
   logic [31:0] bits = 32'h0; // serial bits as sent, newest at bit 0
   int nbits = 0, done_cnt = 0, opc_cnt = 0, cycles = 0, bad_count = 0, checks = 0;
   fss_session #(.TCF_CYCLES(TCF_N)) dut (.core_clk(core_clk), .nrst(nrst),
      .role_caller(role_caller), .start_send(start_send), .start_rate(start_rate),
      .more_pages(more_pages), .operator_call(operator_call), .img_bit(img_bit),
      .img_last(img_last), .rx_frame_valid(rx_frame_valid), .rx_frame_code(rx_frame_code),
      .rx_tcf_done(rx_tcf_done), .rx_tcf_good(rx_tcf_good), .rx_page_good(rx_page_good),
      .tx_frame_ready(tx_frame_ready), .tx_frame_valid(tx_frame_valid),
      .tx_frame_code(tx_frame_code), .train_active(train_active), .tx_rate(tx_rate),
      .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .img_ready(img_ready),
      .coding_1d_only(coding_1d_only), .op_call_seen(op_call_seen),
      .session_done(session_done));
   fss_remote_model rem (.core_clk(core_clk), .nrst(nrst), .tx_frame_valid(tx_frame_valid),
      .tx_frame_code(tx_frame_code), .tx_frame_ready(tx_frame_ready),
      .rx_frame_valid(rx_frame_valid), .rx_frame_code(rx_frame_code),
      .rx_tcf_done(rx_tcf_done), .rx_tcf_good(rx_tcf_good), .rx_page_good(rx_page_good));
   // 125 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // serial capture, pulse counts and the hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (tx_bit_valid === 1'b1) begin
         bits <= {bits[30:0], tx_bit};
         nbits <= nbits + 1;
      end
      if (session_done === 1'b1) done_cnt <= done_cnt + 1;
      if (op_call_seen === 1'b1) opc_cnt <= opc_cnt + 1;
      if (cycles == LIMIT) begin
         bad_count = bad_count + 1;
         summarize();
      end
   end
   // ==========================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask
   // exactly one frame taken, carrying the role bit on top
   task automatic wait_frame(input logic [6:0] c, input logic role);
      int n0;
      int i;
      n0 = rem.n_frames;
      for (i = 0; i < 200 && rem.n_frames == n0; i++) tick();
      chk(rem.n_frames - n0, 1);
      chk({24'h0, rem.last_code}, {24'h0, role, c});
   endtask
   // training burst length and rate
   task automatic train(input logic [2:0] r);
      int n;
      // step off the launching edge so the first training cycle is counted
      #1;
      for (n = 0; n < 3000 && train_active !== 1'b1; n++) tick();
      chk({29'h0, tx_rate}, {29'h0, r});
      for (n = 0; n < 3000 && train_active === 1'b1; n++) tick();
      chk(n, fss_pkg::TRAIN_CYC);
   endtask
   // training check: valid zeros only
   task automatic tcf;
      int n;
      logic ones;
      ones = 1'b0;
      for (n = 0; n < 10 && tx_bit_valid !== 1'b1; n++) tick();
      for (n = 0; n < 100 && tx_bit_valid === 1'b1; n++) begin
         ones = ones | tx_bit;
         tick();
      end
      chk(n, TCF_N - 1);
      chk({31'h0, ones}, 32'h0);
   endtask
   // one sheet of eight bits, then the end marker and the post frame
   task automatic sheet(input logic [6:0] c);
      int i;
      int n0;
      #1;
      for (i = 0; i < 3000 && img_ready !== 1'b1; i++) tick();
      n0 = nbits;
      for (i = 1; i < 8; i++) begin
         @(posedge core_clk);
         img_bit <= PAT[7-i];
         img_last <= (i == 7);
      end
      @(posedge core_clk);
      img_last <= 1'b0;
      img_bit <= PAT[7];
      wait_frame(c, role_caller);
      chk(nbits - n0, 20);
      chk({12'h0, bits[19:0]}, {12'h0, PAT, 12'h249});
   endtask
   task automatic start(input logic [2:0] r);
      @(posedge core_clk);
      start_rate <= r;
      start_send <= 1'b1;
      @(posedge core_clk);
      start_send <= 1'b0;
   endtask
   // ==========================================================
   // scenarios
   // answers in idle, role bit cleared, far role bit ignored
   task automatic answer_side;
      int n;
      rem.tcf_result(1'b1);
      wait_frame(fss_pkg::C_CFR, 1'b0);
      rem.tcf_result(1'b0);
      wait_frame(fss_pkg::C_FTT, 1'b0);
      rem.page_ok();
      wait_frame(fss_pkg::C_MCF, 1'b0);
      n = opc_cnt;
      rem.send_frame({1'b1, fss_pkg::C_PRI});
      wait_frame(fss_pkg::C_PIP, 1'b0);
      chk(opc_cnt - n, 1);
      rem.stall = 6;
      rem.tcf_result(1'b1);
      rem.page_ok();
      wait_frame(fss_pkg::C_CFR, 1'b0);
      n = rem.n_frames;
      repeat (20) tick();
      chk(rem.n_frames - n, 0);
      rem.stall = 0;
   endtask
   // fallback to the floor, then two sheets closed by end of procedure
   task automatic two_pages;
      int n;
      role_caller <= 1'b1;
      more_pages <= 1'b1;
      start(3'h1);
      train(3'h1);
      tcf();
      rem.send_frame({1'b1, fss_pkg::C_FTT});
      train(3'h0);
      tcf();
      rem.send_frame({1'b1, fss_pkg::C_FTT});
      train(3'h0);
      tcf();
      rem.send_frame({1'b1, fss_pkg::C_CFR});
      train(3'h0);
      sheet(fss_pkg::C_MPS);
      more_pages <= 1'b0;
      rem.send_frame({1'b0, fss_pkg::C_MCF});
      sheet(fss_pkg::C_EOP);
      n = done_cnt;
      rem.send_frame({1'b1, fss_pkg::C_MCF});
      wait_frame(fss_pkg::C_DCN, 1'b1);
      chk(done_cnt - n, 1);
   endtask
   // operator call beats more pages; rate request above top is clamped
   task automatic op_call;
      int n;
      role_caller <= 1'b0;
      more_pages <= 1'b1;
      operator_call <= 1'b1;
      start(3'h7);
      train(fss_pkg::RATE_MAX);
      tcf();
      rem.send_frame({1'b1, fss_pkg::C_CFR});
      train(fss_pkg::RATE_MAX);
      sheet(fss_pkg::C_PRI);
      n = opc_cnt;
      rem.send_frame({1'b1, fss_pkg::C_PIP});
      wait_frame(fss_pkg::C_DCN, 1'b0);
      chk(opc_cnt - n, 1);
      operator_call <= 1'b0;
   endtask
   task automatic summarize;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // main sequence: reset, idle outputs, then the sessions
   initial begin
      nrst = 1'b0;
      role_caller = 1'b0;
      start_send = 1'b0;
      start_rate = 3'h0;
      more_pages = 1'b0;
      operator_call = 1'b0;
      img_bit = PAT[7];
      img_last = 1'b0;
      repeat (16) @(posedge core_clk);
      chk({27'h0, tx_frame_valid, train_active, img_ready, tx_bit_valid, coding_1d_only},
         32'h1);
      nrst <= 1'b1;
      tick();
      answer_side();
      two_pages();
      op_call();
      summarize();
   end
endmodule
